/* rtl/diag_pkg.sv */
package diag_pkg;

   // -------------------------------------------------------------------
   // Sources and widths
   // -------------------------------------------------------------------
   localparam int NUM_DI   = 16;
   localparam int NUM_CNT  = 3;
   localparam int NUM_SRC  = 28;
   localparam int NUM_GRP  = 7;
   localparam int ADDR_W   = 8;
   localparam int SPREAD_W = 56;

   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] OFF_REC_W0 = 8'h00;
   localparam logic [7:0] OFF_REC_W1 = 8'h04;
   localparam logic [7:0] OFF_REC_W2 = 8'h08;
   localparam logic [7:0] OFF_REC_W3 = 8'h0C;
   localparam logic [7:0] OFF_CTRL   = 8'h10;
   localparam logic [7:0] OFF_ISTAT  = 8'h14;
   localparam logic [7:0] OFF_IMASK  = 8'h18;
   localparam logic [7:0] OFF_PEND   = 8'h1C;
   localparam logic [7:0] OFF_LOST   = 8'h20;

   // -------------------------------------------------------------------
   // Control and interrupt fields, reset values
   // -------------------------------------------------------------------
   localparam int CTRL_DIAG_EN = 0;
   localparam int CTRL_DIGITAL = 1;
   localparam int CTRL_MORE    = 2;
   localparam logic [2:0] CTRL_RESET  = 3'h2;
   localparam int IRQ_PROC = 0;
   localparam int IRQ_DIN  = 1;
   localparam int IRQ_DOUT = 2;
   localparam logic [2:0] IMASK_RESET = 3'h0;
   localparam logic [2:0] ISTAT_RESET = 3'h0;

   // -------------------------------------------------------------------
   // Record fields and fixed codes
   // -------------------------------------------------------------------
   localparam int B0_FAIL = 0;
   localparam int B0_EXT  = 2;
   localparam int B0_CHAN = 3;
   localparam int B1_INFO = 4;
   localparam int B3_LOST = 6;
   localparam int B4_MORE = 7;
   localparam logic [3:0] CLASS_ANALOG  = 4'h5;
   localparam logic [3:0] CLASS_DIGITAL = 4'hF;
   localparam logic [6:0] CHAN_TYPE_DI  = 7'h70;
   localparam logic [7:0] DIAG_BITS     = 8'h08;
   localparam logic [7:0] NUM_CHAN      = 8'h08;

endpackage : diag_pkg

/* rtl/trk_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface trk_if;
   logic [27:0] ev;
   logic [27:0] ack;
   logic [27:0] lost_clr;
   logic [27:0] pending;
   logic [27:0] lost;
   logic [27:0] lost_new;

   modport tracker (input ev, ack, lost_clr,
                    output pending, lost, lost_new);
   modport owner   (output ev, ack, lost_clr,
                    input pending, lost, lost_new);
endinterface : trk_if

`default_nettype wire

/* rtl/sync2.sv */
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
   parameter int W = 1
) (
   input  wire logic         mclk, // System clock.
   input  wire logic         rst,  // Synchronous reset, active high.
   input  wire logic [W-1:0] d,    // Asynchronous level inputs.
   output logic      [W-1:0] q     // Synchronised levels.
);
   logic [W-1:0] s1;
   logic [W-1:0] next_s1;
   logic [W-1:0] next_q;

   always_comb begin
      next_s1 = d;
      next_q  = s1;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s1 <= '0;
         q  <= '0;
      end else begin
         s1 <= next_s1;
         q  <= next_q;
      end
   end
endmodule : sync2

`default_nettype wire

/* rtl/src_tracker.sv */
`timescale 1ns/1ps
`default_nettype none

module src_tracker (
   input  wire logic mclk, // System clock.
   input  wire logic rst,  // Synchronous reset, active high.
   trk_if.tracker    t     // Event, acknowledge and flag bundle.
);
   logic [27:0] pending;
   logic [27:0] lost;
   logic [27:0] next_pending;
   logic [27:0] next_lost;
   logic [27:0] hit;

   // A source is busy from its event until software acknowledges it.
   always_comb begin
      hit          = t.ev & pending & ~t.ack; // R16
      next_pending = (pending & ~t.ack) | t.ev;
      next_lost    = (lost & ~t.lost_clr) | hit; // R16
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pending <= '0;
         lost    <= '0;
      end else begin
         pending <= next_pending;
         lost    <= next_lost;
      end
   end

   assign t.pending  = pending;
   assign t.lost     = lost;
   assign t.lost_new = hit;
endmodule : src_tracker

`default_nettype wire

/* rtl/diag_record_builder.sv */
// What this block does
// [R1] Outgoing diagnostic message on error clearing, only while diag enable set.
// [R2] Base byte 0: bit0 module failure, bit2 external, bit3 channel error.
// [R3] Base byte 1 bits 3..0 give class: 0101b analog, 1111b digital.
// [R4] Base byte 1 bit 4 flags channel info; bits 7..5 read zero.
// [R5] Outgoing base record has bytes 2 and 3 at zero.
// [R6] Base record layout is the same for every technology function.
// [R7] Extended record is 16 bytes: base record then twelve specific bytes.
// [R8] Extended byte 4 bits 6..0 hold channel type, here 70h.
// [R9] Extended byte 4 bit 7 flags that more channel types follow.
// [R10] Extended byte 5 reports 08h diagnostic bits per channel.
// [R11] Extended byte 6 reports 08h channels.
// [R12] Extended byte 7: input group errors, counter errors, bit 7 reserved.
// [R13] Bytes 8..11 flag lost interrupts of 16 inputs on even bits.
// [R14] Bytes 12..14 flag lost counter events on even bits.
// [R15] Extended byte 15 reads zero.
// [R16] A repeat event while the first is serviced raises a diagnostic.
// [R17] Incoming base byte 3 bit 6 flags a lost process interrupt.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module diag_record_builder (
   input  wire logic        mclk,        // System clock, 100 MHz.
   input  wire logic        rst,         // Synchronous reset, active high.
   input  wire logic        psel,        // APB select.
   input  wire logic        penable,     // APB access phase.
   input  wire logic        pwrite,      // APB direction, high for write.
   input  wire logic [7:0]  paddr,       // APB byte address.
   input  wire logic [31:0] pwdata,      // APB write data.
   output logic      [31:0] prdata,      // APB read data.
   output logic             pready,      // APB ready.
   output logic             pslverr,     // APB error, unmapped address.
   input  wire logic [15:0] di_edge,     // Input edge events, one pulse.
   input  wire logic [11:0] cnt_event,   // Counter events, four each.
   input  wire logic        fail_pin,    // Module failure level.
   input  wire logic        ext_err_pin, // External error level.
   input  wire logic [6:0]  grp_err_pin, // Channel group error levels.
   output logic             irq,         // Interrupt, active high level.
   output logic             fault_led    // On inside the diagnostic window.
);

   // -------------------------------------------------------------------
   // Error inputs and event tracking
   // -------------------------------------------------------------------
   logic [8:0]  err_sync;
   logic        fail;
   logic        ext_err;
   logic [6:0]  grp_err;
   logic        wr_go;
   logic        rd_go;

   sync2 #(.W(9)) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .d    ({grp_err_pin, ext_err_pin, fail_pin}),
      .q    (err_sync)
   );

   assign fail    = err_sync[0];
   assign ext_err = err_sync[1];
   assign grp_err = err_sync[8:2];

   trk_if trk ();

   src_tracker u_trk (
      .mclk (mclk),
      .rst  (rst),
      .t    (trk.tracker)
   );

   assign trk.ev       = {cnt_event, di_edge};
   assign trk.ack      = (wr_go && paddr == diag_pkg::OFF_PEND)
                         ? pwdata[27:0] : 28'h0000000;
   assign trk.lost_clr = (wr_go && paddr == diag_pkg::OFF_LOST)
                         ? pwdata[27:0] : 28'h0000000;

   // -------------------------------------------------------------------
   // Record composition
   // -------------------------------------------------------------------
   logic [2:0]  ctrl;
   logic        any_lost;
   logic        chan_err;
   logic        err_any;
   logic [7:0]  byte0;
   logic [7:0]  byte1;
   logic [7:0]  byte3_in;
   logic [31:0] base_in;
   logic [31:0] base_out;
   logic [diag_pkg::SPREAD_W-1:0] spread;
   logic [31:0] ext_w1;
   logic [31:0] ext_w2;
   logic [31:0] ext_w3;

   // Byte 0 and 1 are common to every function and both message kinds.
   always_comb begin
      // A loss is counted in the cycle it happens, so the incoming record
      // stored with the message already carries its flag.
      any_lost = |(trk.lost | trk.lost_new); // R17
      chan_err = (|grp_err) | any_lost;
      err_any  = fail | ext_err | chan_err;
      byte0    = 8'h00;
      byte0[diag_pkg::B0_FAIL] = fail; // R2
      byte0[diag_pkg::B0_EXT]  = ext_err; // R2
      byte0[diag_pkg::B0_CHAN] = chan_err; // R2
      byte1    = 8'h00; // R4
      byte1[3:0] = ctrl[diag_pkg::CTRL_DIGITAL] ? diag_pkg::CLASS_DIGITAL
                                                : diag_pkg::CLASS_ANALOG; // R3
      byte1[diag_pkg::B1_INFO] = chan_err; // R4
      byte3_in = 8'h00;
      byte3_in[diag_pkg::B3_LOST] = any_lost; // R17
      base_in  = {byte3_in, 8'h00, byte1, byte0}; // R6
      base_out = {8'h00, 8'h00, byte1, byte0}; // R5
   end

   // Each lost flag lands on an even bit, inputs first, then counters.
   always_comb begin
      spread = '0;
      for (int i = 0; i < diag_pkg::NUM_SRC; i++) begin
         spread[2*i] = trk.lost[i]; // R13 R14
      end
   end

   always_comb begin
      ext_w1 = {1'b0, grp_err,
                diag_pkg::NUM_CHAN, // R11
                diag_pkg::DIAG_BITS, // R10
                ctrl[diag_pkg::CTRL_MORE], // R9
                diag_pkg::CHAN_TYPE_DI}; // R8 R12
      ext_w2 = spread[31:0]; // R13
      ext_w3 = {8'h00, spread[55:32]}; // R14 R15
   end

   // -------------------------------------------------------------------
   // Diagnostic messages
   // -------------------------------------------------------------------
   logic        err_prev;
   logic        msg_in;
   logic        msg_out;
   logic        err_rise;
   logic        err_fall;
   logic [31:0] snap;
   logic        next_err_prev;
   logic [31:0] next_snap;
   logic        next_led;

   // The stored record follows the latest event even with messages off,
   // so software polling still sees the most recent diagnostic state.
   always_comb begin
      err_rise      = (err_any & ~err_prev) | (|trk.lost_new);
      err_fall      = ~err_any & err_prev;
      msg_in        = ctrl[diag_pkg::CTRL_DIAG_EN] & err_rise; // R16
      msg_out       = ctrl[diag_pkg::CTRL_DIAG_EN] & err_fall; // R1
      next_err_prev = err_any;
      next_snap     = snap;
      if (err_rise) begin
         next_snap = base_in; // R17
      end else if (err_fall) begin
         next_snap = base_out; // R5
      end
      next_led = msg_in | (fault_led & err_any & ~msg_out);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         err_prev  <= 1'b0;
         snap      <= 32'h00000000;
         fault_led <= 1'b0;
      end else begin
         err_prev  <= next_err_prev;
         snap      <= next_snap;
         fault_led <= next_led;
      end
   end

   // -------------------------------------------------------------------
   // Interrupt status and mask
   // -------------------------------------------------------------------
   logic [2:0] istat;
   logic [2:0] imask;
   logic [2:0] istat_set;
   logic [2:0] istat_clr;
   logic [2:0] next_ctrl;
   logic [2:0] next_istat;
   logic [2:0] next_imask;
   logic       next_irq;

   // Hardware sets win over a software clear in the same cycle.
   always_comb begin
      istat_set = 3'h0;
      istat_set[diag_pkg::IRQ_PROC] = |trk.ev;
      istat_set[diag_pkg::IRQ_DIN]  = msg_in; // R16
      istat_set[diag_pkg::IRQ_DOUT] = msg_out; // R1
      istat_clr = (wr_go && paddr == diag_pkg::OFF_ISTAT)
                  ? pwdata[2:0] : 3'h0;
      next_istat = (istat & ~istat_clr) | istat_set;
      next_ctrl  = (wr_go && paddr == diag_pkg::OFF_CTRL)
                   ? pwdata[2:0] : ctrl;
      next_imask = (wr_go && paddr == diag_pkg::OFF_IMASK)
                   ? pwdata[2:0] : imask;
      next_irq   = |(istat & imask);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl  <= diag_pkg::CTRL_RESET;
         istat <= diag_pkg::ISTAT_RESET;
         imask <= diag_pkg::IMASK_RESET;
         irq   <= 1'b0;
      end else begin
         ctrl  <= next_ctrl;
         istat <= next_istat;
         imask <= next_imask;
         irq   <= next_irq;
      end
   end

   // -------------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------------
   logic [31:0] rd_mux;
   logic        mapped;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;

   // Every access waits one cycle in the access phase, then completes.
   always_comb begin
      wr_go  = psel & penable & pready & pwrite & ~pslverr;
      rd_go  = psel & penable & ~pready;
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         diag_pkg::OFF_REC_W0: rd_mux = snap; // R7
         diag_pkg::OFF_REC_W1: rd_mux = ext_w1; // R7
         diag_pkg::OFF_REC_W2: rd_mux = ext_w2;
         diag_pkg::OFF_REC_W3: rd_mux = ext_w3;
         diag_pkg::OFF_CTRL:   rd_mux = {29'h00000000, ctrl};
         diag_pkg::OFF_ISTAT:  rd_mux = {29'h00000000, istat};
         diag_pkg::OFF_IMASK:  rd_mux = {29'h00000000, imask};
         diag_pkg::OFF_PEND:   rd_mux = {4'h0, trk.pending};
         diag_pkg::OFF_LOST:   rd_mux = {4'h0, trk.lost};
         default:              mapped = 1'b0;
      endcase
      next_pready  = rd_go;
      next_pslverr = rd_go & ~mapped;
      next_prdata  = prdata;
      if (rd_go) begin
         next_prdata = (pwrite | ~mapped) ? 32'h00000000 : rd_mux;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

endmodule : diag_record_builder

`default_nettype wire

/* sim/diag_record_builder_props.sv */
`timescale 1ns/1ps
`default_nettype none

module diag_record_builder_checker (
   input wire logic        mclk,      // System clock.
   input wire logic        rst,       // Synchronous reset.
   input wire logic        psel,      // APB select.
   input wire logic        penable,   // APB access phase.
   input wire logic        pwrite,    // APB direction.
   input wire logic [7:0]  paddr,     // APB byte address.
   input wire logic [31:0] prdata,    // APB read data.
   input wire logic        pready,    // APB ready.
   input wire logic        pslverr,   // APB error.
   input wire logic        irq,       // Interrupt level.
   input wire logic        fault_led  // Diagnostic window light.
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_rdy_lat;
      $rose(penable) && psel |=> pready;
   endproperty
   a_rdy_lat: assert property (p_rdy_lat) else $error("late ready");
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("long ready");
   property p_rdy_only;
      pready |-> psel && penable;
   endproperty
   a_rdy_only: assert property (p_rdy_only) else $error("stray ready");
   property p_unmapped;
      pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error");
   property p_mapped;
      pready && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("false error");
   property p_wr_zero;
      pready && pwrite |-> prdata == 32'h0;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("write data");
   property p_w0;
      pready && !pwrite && paddr == 8'h00 |-> (prdata & 32'hBFFFE0F2) == 0;
   endproperty
   a_w0: assert property (p_w0) else $error("base fixed bits");
   property p_w1;
      pready && !pwrite && paddr == 8'h04 |->
         prdata[23:8] == 16'h0808 && prdata[6:0] == 7'h70 && !prdata[31];
   endproperty
   a_w1: assert property (p_w1) else $error("ext bytes 4-7");
   property p_w2;
      pready && !pwrite && paddr == 8'h08 |-> (prdata & 32'hAAAAAAAA) == 0;
   endproperty
   a_w2: assert property (p_w2) else $error("odd input bits");
   property p_w3;
      pready && !pwrite && paddr == 8'h0C |-> (prdata & 32'hFFAAAAAA) == 0;
   endproperty
   a_w3: assert property (p_w3) else $error("counter bytes");
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_led: cover property ($fell(fault_led));
endmodule : diag_record_builder_checker

`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_t;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, e;
   logic        irq, fault_led, fail_pin, ext_err_pin;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] di_edge;
   logic [11:0] cnt_event;
   logic [6:0]  grp_err_pin;
   int          fails = 0, compares = 0, cyc = 0;
   row_t rows[10] = '{'{8'h00, 32'h0, 1'b0}, '{8'h04, 32'h00080870, 1'b0},
      '{8'h08, 32'h0, 1'b0}, '{8'h0C, 32'h0, 1'b0}, '{8'h10, 32'h2, 1'b0},
      '{8'h14, 32'h0, 1'b0}, '{8'h18, 32'h0, 1'b0}, '{8'h1C, 32'h0, 1'b0},
      '{8'h20, 32'h0, 1'b0}, '{8'h24, 32'h0, 1'b1}};

   diag_record_builder u_diag_record_builder (.mclk(mclk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .di_edge(di_edge), .cnt_event(cnt_event),
      .fail_pin(fail_pin), .ext_err_pin(ext_err_pin),
      .grp_err_pin(grp_err_pin), .irq(irq), .fault_led(fault_led));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      compares++;
      if (g !== x) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdm(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, x, r & m);
   endtask : rdm

   task automatic pulse(input logic [15:0] d, input logic [11:0] c);
      repeat (2) begin
         @(posedge mclk);
         di_edge   <= d;
         cnt_event <= c;
         @(posedge mclk);
         di_edge   <= 16'h0;
         cnt_event <= 12'h0;
         repeat (2) @(posedge mclk);
      end
   endtask : pulse

   task automatic wrap_up();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   initial begin
      {rst, psel, penable, pwrite, fail_pin, ext_err_pin} = 6'h20;
      {paddr, pwdata, di_edge, cnt_event, grp_err_pin} = '0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         rdm("row data", rows[i].a, 32'hFFFFFFFF, rows[i].d);
         chk("row err", {31'h0, rows[i].e}, {31'h0, e});
      end
      apb(1'b1, 8'h24, 32'hFFFFFFFF);
      chk("wr err", 32'h1, {31'h0, e});
      apb(1'b1, diag_pkg::OFF_REC_W1, 32'hFFFFFFFF);
      rdm("w1 ro", diag_pkg::OFF_REC_W1, 32'hFFFFFFFF, 32'h00080870);
      $display("test reset map done");
      apb(1'b1, diag_pkg::OFF_CTRL, 32'h3);
      pulse(16'h0020, 12'h0);
      rdm("pend", diag_pkg::OFF_PEND, 32'hFFFFFFFF, 32'h20);
      rdm("lost", diag_pkg::OFF_LOST, 32'hFFFFFFFF, 32'h20);
      rdm("istat in", diag_pkg::OFF_ISTAT, 32'hFFFFFFFF, 32'h3);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, diag_pkg::OFF_IMASK, 32'h7);
      repeat (2) @(posedge mclk);
      chk("irq", 32'h1, {31'h0, irq});
      chk("led on", 32'h1, {31'h0, fault_led});
      rdm("w2", diag_pkg::OFF_REC_W2, 32'hFFFFFFFF, 32'h400);
      rdm("w0 in", 8'h00, 32'h40000F00, 32'h40000F00);
      pulse(16'h0, 12'h200);
      rdm("w3", diag_pkg::OFF_REC_W3, 32'hFFFFFFFF, 32'h40000);
      apb(1'b1, diag_pkg::OFF_PEND, 32'h0FFFFFFF);
      apb(1'b1, diag_pkg::OFF_LOST, 32'h0FFFFFFF);
      repeat (2) @(posedge mclk);
      rdm("istat out", diag_pkg::OFF_ISTAT, 32'hFFFFFFFF, 32'h7);
      rdm("w0 out", 8'h00, 32'hFFFF0000, 32'h0);
      chk("led off", 32'h0, {31'h0, fault_led});
      apb(1'b1, diag_pkg::OFF_ISTAT, 32'h7);
      repeat (2) @(posedge mclk);
      chk("irq clear", 32'h0, {31'h0, irq});
      $display("test lost events done");
      ext_err_pin <= 1'b1;
      grp_err_pin <= 7'h10;
      repeat (6) @(posedge mclk);
      rdm("w0 grp", 8'h00, 32'h0000000F, 32'h0000000C);
      rdm("w1 grp", diag_pkg::OFF_REC_W1, 32'hFFFFFFFF, 32'h10080870);
      ext_err_pin <= 1'b0;
      grp_err_pin <= 7'h0;
      repeat (6) @(posedge mclk);
      rdm("istat grp", diag_pkg::OFF_ISTAT, 32'hFFFFFFFF, 32'h6);
      apb(1'b1, diag_pkg::OFF_ISTAT, 32'h7);
      apb(1'b1, diag_pkg::OFF_CTRL, 32'h4);
      fail_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      rdm("w0 fail", 8'h00, 32'h00000F0F, 32'h00000501);
      rdm("w1 more", diag_pkg::OFF_REC_W1, 32'hFFFFFFFF, 32'h000808F0);
      fail_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      rdm("istat off", diag_pkg::OFF_ISTAT, 32'hFFFFFFFF, 32'h0);
      rdm("w0 off", 8'h00, 32'hFFFF0000, 32'h0);
      $display("test error pins done");
      apb(1'b1, diag_pkg::OFF_CTRL, 32'h1);
      fail_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("irq pre", 32'h1, {31'h0, irq});
      chk("led pre", 32'h1, {31'h0, fault_led});
      rst      <= 1'b1;
      fail_pin <= 1'b0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("irq rst", 32'h0, {31'h0, irq});
      chk("led rst", 32'h0, {31'h0, fault_led});
      rdm("ctrl rst", diag_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h2);
      rdm("istat rst", diag_pkg::OFF_ISTAT, 32'hFFFFFFFF, 32'h0);
      rdm("w0 rst", 8'h00, 32'hFFFFFFFF, 32'h0);
      $display("test reset again done");
      wrap_up();
   end
endmodule : tb

bind diag_record_builder diag_record_builder_checker
   u_diag_record_builder_checker (.mclk(mclk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq), .fault_led(fault_led));

`default_nettype wire
